// [clk6_cfg_pkg.sv]
// constants and carrier types for the sixth output bank and first-pll spread sequencer
//////////////////////////////////////////////////////////////////////////////////////
// Contract
// - mode 00 off, 01 by one, 10 by two, 11 q+2
// - two ten-bit divider copies, default two, both used
// - polarity bit zero passes, one inverts
// - disabled drive: 0x float, 10 low, 11 high
// - step every programmed cycles; zero disables spread
// - use only programmed number of samples
// - dither bit enables lsb dither, default off
// - six-bit offset is first waveform sample
// - each later point adds next unsigned delta
//////////////////////////////////////////////////////////////////////////////////////
package clk6_cfg_pkg;

  // register offsets on the configuration port
  localparam logic [7:0] SIXTH_CLOCK_OUTPUT_CTRL_ADDR = 8'h5C;     // polarity, slew, disabled drive mode
  localparam logic [7:0] SIXTH_CLOCK_OUTPUT_DIV_LO_ADDR = 8'h5D;   // low divider bits and both mode copies
  localparam logic [7:0] SIXTH_CLOCK_OUTPUT_DIV_HI_A_ADDR = 8'h5E; // divider bits 9:2, set a
  localparam logic [7:0] SIXTH_CLOCK_OUTPUT_DIV_HI_B_ADDR = 8'h5F; // divider bits 9:2, set b
  localparam logic [7:0] SS_STEP_ADDR = 8'h60;       // step period and sample count
  localparam logic [7:0] SS_DITH_ADDR = 8'h61;       // dither, doubler, start offset
  localparam logic [7:0] SS_DELTA_BASE_ADDR = 8'h62; // first of the delta sample registers
  localparam int SS_DELTA_REGS = 6;                  // two deltas per register
  localparam int SS_DELTAS = 12;                     // delta sample memory depth

  // values after reset
  localparam logic [7:0] SIXTH_CLOCK_OUTPUT_CTRL_RESET = 8'h00;
  localparam logic [7:0] SIXTH_CLOCK_OUTPUT_DIV_LO_RESET = 8'hBB;
  localparam logic [7:0] SIXTH_CLOCK_OUTPUT_DIV_HI_RESET = 8'h00;
  localparam logic [7:0] SS_REG_RESET = 8'h00;

  // field positions
  localparam int CTRL_OEM_LSB = 6;    // disabled drive mode, two bits
  localparam int CTRL_SLEW_LSB = 4;   // slew setting, stored only
  localparam int CTRL_INV_BIT = 2;    // polarity select
  localparam logic [7:0] CTRL_WRITABLE = 8'hF4; // bits 3, 1, 0 are reserved
  localparam int DIV_MODE_A_LSB = 0;
  localparam int DIV_Q_A_LSB = 2;
  localparam int DIV_MODE_B_LSB = 4;
  localparam int DIV_Q_B_LSB = 6;
  localparam int SS_PERIOD_LSB = 4;
  localparam int SS_COUNT_LSB = 0;
  localparam int SS_DITHER_BIT = 7;
  localparam int SS_DOUBLER_BIT = 6;
  localparam int SS_OFFSET_LSB = 0;

  // divide mode encoding
  localparam logic [1:0] DIV_MODE_OFF = 2'h0;
  localparam logic [1:0] DIV_MODE_BY1 = 2'h1;
  localparam logic [1:0] DIV_MODE_BY2 = 2'h2;
  localparam logic [1:0] DIV_MODE_BYQ = 2'h3;
  localparam logic [10:0] DIV_Q_ADDEND = 11'h002;

  // disabled drive mode encoding (bit 1 clear means float)
  localparam logic [1:0] OEM_PARK_LOW = 2'h2;
  localparam logic [1:0] OEM_PARK_HIGH = 2'h3;

  // dither generator seed; the taps are fixed in spread_seq
  localparam logic [7:0] LFSR_SEED = 8'h01;

  // sixth output control fields
  typedef struct packed {
    logic [1:0] drive_mode; // what the pin does while disabled
    logic invert;           // polarity select
  } out_ctrl_t;

  // first pll spread configuration
  typedef struct packed {
    logic [3:0] step_period;  // pfd cycles per step, zero is off
    logic [3:0] sample_count; // samples taken from memory
    logic dither;             // lsb dither on the modulator
    logic [5:0] start_offset; // first sample of the waveform
  } spread_cfg_t;

endpackage

// [spread_seq.sv]
// spread waveform sequencer for the first pll
`timescale 1ns/1ns
module spread_seq (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire clk6_cfg_pkg::spread_cfg_t cfg,
  input wire logic [47:0] deltas,
  output logic [7:0] frac_word,
  output logic step_pulse,
  output logic spread_active,
  output logic dither_lsb
);

  typedef enum logic {SS_OFF, SS_RUN} ss_state_t;

  // pick one delta; indexes past the memory add nothing
  function automatic logic [7:0] delta_at(input logic [47:0] d, input logic [3:0] i);
    logic [7:0] v;
    v = 8'h00;
    if (i < 4'(clk6_cfg_pkg::SS_DELTAS)) begin
      v = {4'h0, d[i*4 +: 4]};
    end
    return v;
  endfunction

  ss_state_t state, next_state;
  logic [3:0] step_cnt, next_step_cnt; // pfd cycles within one step
  logic [3:0] idx, next_idx;           // current sample index
  logic [7:0] next_frac;
  logic next_step;
  logic [7:0] lfsr, next_lfsr;         // free-running dither source
  logic next_dither;
  logic next_active;                   // run flag, registered so the pin comes from a flop

  // next waveform point, step timing and dither
  always_comb begin
    next_state = state;
    next_step_cnt = step_cnt;
    next_idx = idx;
    next_frac = frac_word;
    next_step = 1'b0;
    next_lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    next_dither = cfg.dither & lfsr[0];
    case (state)
      SS_OFF: begin
        // park on the offset so the first point is right when spread starts
        next_step_cnt = 4'h0;
        next_idx = 4'h0;
        next_frac = {2'h0, cfg.start_offset};
        if (cfg.step_period != 4'h0) begin
          next_state = SS_RUN;
        end
      end
      SS_RUN: begin
        if (cfg.step_period == 4'h0) begin
          next_state = SS_OFF;
          next_frac = {2'h0, cfg.start_offset};
          next_idx = 4'h0;
          next_step_cnt = 4'h0;
        end else if (step_cnt >= cfg.step_period - 4'h1) begin
          next_step_cnt = 4'h0;
          next_step = 1'b1;
          if (cfg.sample_count == 4'h0 || idx >= cfg.sample_count - 4'h1) begin
            // count used up: restart from the offset and repeat
            next_idx = 4'h0;
            next_frac = {2'h0, cfg.start_offset};
          end else begin
            next_idx = idx + 4'h1;
            next_frac = frac_word + delta_at(deltas, idx);
          end
        end else begin
          next_step_cnt = step_cnt + 4'h1;
        end
      end
      default: next_state = SS_OFF;
    endcase
    next_active = (next_state == SS_RUN);
  end

  // register the sequencer state
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= SS_OFF;
      step_cnt <= 4'h0;
      idx <= 4'h0;
      frac_word <= 8'h00;
      step_pulse <= 1'b0;
      lfsr <= clk6_cfg_pkg::LFSR_SEED;
      dither_lsb <= 1'b0;
      spread_active <= 1'b0;
    end else begin
      state <= next_state;
      step_cnt <= next_step_cnt;
      idx <= next_idx;
      frac_word <= next_frac;
      step_pulse <= next_step;
      lfsr <= next_lfsr;
      dither_lsb <= next_dither;
      spread_active <= next_active;
    end
  end

  // a step that is not the last adds exactly the indexed delta
  sequence s_mid_step;
    state == SS_RUN && cfg.step_period != 4'h0 && step_cnt >= cfg.step_period - 4'h1
      && cfg.sample_count != 4'h0 && idx < cfg.sample_count - 4'h1;
  endsequence

  a_delta_add: assert property (@(posedge core_clk) disable iff (!rst_b)
    s_mid_step ##0 $stable(deltas) |=> frac_word == $past(frac_word) + $past(delta_at(deltas, idx)))
    else $error("spread point did not add the delta");

  a_spread_off: assert property (@(posedge core_clk) disable iff (!rst_b)
    cfg.step_period == 4'h0 |=> !step_pulse)
    else $error("step while spread disabled");

  a_step_spacing: assert property (@(posedge core_clk) disable iff (!rst_b)
    step_pulse && cfg.step_period == 4'h2 && $stable(cfg.step_period)
      |=> !step_pulse ##1 (step_pulse || cfg.step_period != 4'h2))
    else $error("step spacing differs from period");

  a_wrap_offset: assert property (@(posedge core_clk) disable iff (!rst_b)
    state == SS_RUN && cfg.step_period != 4'h0 && step_cnt >= cfg.step_period - 4'h1
      && idx >= cfg.sample_count - 4'h1 |=> frac_word == {2'h0, $past(cfg.start_offset)}
      && idx == 4'h0)
    else $error("waveform did not restart at offset");

  a_dither_gate: assert property (@(posedge core_clk) disable iff (!rst_b)
    !cfg.dither |=> !dither_lsb)
    else $error("dither seen while disabled");

endmodule

// [output6_divider_and_spread_cfg.sv]
// sixth output bank divider, drive control and first-pll spread configuration
`timescale 1ns/1ns
module output6_divider_and_spread_cfg (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  output logic [7:0] cfg_rdata,
  input wire logic src_tick,
  input wire logic multi_config_operation,
  input wire logic config_sel_pin,
  input wire logic out_f_enable_bit,
  input wire logic shutdown_enable_pin,
  output logic sixth_clock_output,
  output logic sixth_clock_output_oe,
  output logic [7:0] pll_a_spread_frac,
  output logic pll_a_spread_step,
  output logic pll_a_spread_active,
  output logic pll_a_lsb_dither,
  output logic pll_a_doubler
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // divide ratio for one mode and divider value; zero means stopped
  function automatic logic [10:0] divide_ratio(input logic [1:0] mode, input logic [9:0] q);
    logic [10:0] r;
    r = 11'h000;
    case (mode)
      clk6_cfg_pkg::DIV_MODE_OFF: r = 11'h000;
      clk6_cfg_pkg::DIV_MODE_BY1: r = 11'h001;
      clk6_cfg_pkg::DIV_MODE_BY2: r = 11'h002;
      clk6_cfg_pkg::DIV_MODE_BYQ: r = {1'b0, q} + clk6_cfg_pkg::DIV_Q_ADDEND;
      default: r = 11'h000;
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers

  logic [7:0] out_ctrl, next_out_ctrl;     // polarity, slew, disabled drive
  logic [7:0] div_lo, next_div_lo;         // mode copies and low divider bits
  logic [7:0] div_hi_a, next_div_hi_a;     // divider high bits, set a
  logic [7:0] div_hi_b, next_div_hi_b;     // divider high bits, set b
  logic [7:0] ss_step, next_ss_step;       // spread step period and count
  logic [7:0] ss_dith, next_ss_dith;       // dither, doubler, offset
  logic [7:0] ss_delta [clk6_cfg_pkg::SS_DELTA_REGS];
  logic [7:0] next_ss_delta [clk6_cfg_pkg::SS_DELTA_REGS];
  logic [7:0] next_rdata;

  // writes land the cycle after the strobe; reads answer one cycle later
  always_comb begin
    next_out_ctrl = out_ctrl;
    next_div_lo = div_lo;
    next_div_hi_a = div_hi_a;
    next_div_hi_b = div_hi_b;
    next_ss_step = ss_step;
    next_ss_dith = ss_dith;
    next_ss_delta = ss_delta;
    next_rdata = 8'h00; // unmapped reads and idle cycles give zero
    if (cfg_wr) begin
      case (cfg_addr)
        // reserved control bits never store, so they read back zero
        clk6_cfg_pkg::SIXTH_CLOCK_OUTPUT_CTRL_ADDR: next_out_ctrl = cfg_wdata & clk6_cfg_pkg::CTRL_WRITABLE;
        clk6_cfg_pkg::SIXTH_CLOCK_OUTPUT_DIV_LO_ADDR: next_div_lo = cfg_wdata;
        clk6_cfg_pkg::SIXTH_CLOCK_OUTPUT_DIV_HI_A_ADDR: next_div_hi_a = cfg_wdata;
        clk6_cfg_pkg::SIXTH_CLOCK_OUTPUT_DIV_HI_B_ADDR: next_div_hi_b = cfg_wdata;
        clk6_cfg_pkg::SS_STEP_ADDR: next_ss_step = cfg_wdata;
        clk6_cfg_pkg::SS_DITH_ADDR: next_ss_dith = cfg_wdata;
        default: begin
          for (int i = 0; i < clk6_cfg_pkg::SS_DELTA_REGS; i++) begin
            if (cfg_addr == clk6_cfg_pkg::SS_DELTA_BASE_ADDR + 8'(i)) begin
              next_ss_delta[i] = cfg_wdata;
            end
          end
        end
      endcase
    end
    if (cfg_rd) begin
      case (cfg_addr)
        clk6_cfg_pkg::SIXTH_CLOCK_OUTPUT_CTRL_ADDR: next_rdata = out_ctrl;
        clk6_cfg_pkg::SIXTH_CLOCK_OUTPUT_DIV_LO_ADDR: next_rdata = div_lo;
        clk6_cfg_pkg::SIXTH_CLOCK_OUTPUT_DIV_HI_A_ADDR: next_rdata = div_hi_a;
        clk6_cfg_pkg::SIXTH_CLOCK_OUTPUT_DIV_HI_B_ADDR: next_rdata = div_hi_b;
        clk6_cfg_pkg::SS_STEP_ADDR: next_rdata = ss_step;
        clk6_cfg_pkg::SS_DITH_ADDR: next_rdata = ss_dith;
        default: begin
          for (int i = 0; i < clk6_cfg_pkg::SS_DELTA_REGS; i++) begin
            if (cfg_addr == clk6_cfg_pkg::SS_DELTA_BASE_ADDR + 8'(i)) begin
              next_rdata = ss_delta[i];
            end
          end
        end
      endcase
    end
  end

  // register file storage
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      out_ctrl <= clk6_cfg_pkg::SIXTH_CLOCK_OUTPUT_CTRL_RESET;
      div_lo <= clk6_cfg_pkg::SIXTH_CLOCK_OUTPUT_DIV_LO_RESET;
      div_hi_a <= clk6_cfg_pkg::SIXTH_CLOCK_OUTPUT_DIV_HI_RESET;
      div_hi_b <= clk6_cfg_pkg::SIXTH_CLOCK_OUTPUT_DIV_HI_RESET;
      ss_step <= clk6_cfg_pkg::SS_REG_RESET;
      ss_dith <= clk6_cfg_pkg::SS_REG_RESET;
      for (int i = 0; i < clk6_cfg_pkg::SS_DELTA_REGS; i++) begin
        ss_delta[i] <= clk6_cfg_pkg::SS_REG_RESET;
      end
      cfg_rdata <= 8'h00;
    end else begin
      out_ctrl <= next_out_ctrl;
      div_lo <= next_div_lo;
      div_hi_a <= next_div_hi_a;
      div_hi_b <= next_div_hi_b;
      ss_step <= next_ss_step;
      ss_dith <= next_ss_dith;
      ss_delta <= next_ss_delta;
      cfg_rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic sel_s1, sel_s2;   // configuration select pin
  logic shut_s1, shut_s2; // shutdown / enable pin

  // both pins are asynchronous; only the second stage is used
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sel_s1 <= 1'b0;
      sel_s2 <= 1'b0;
      shut_s1 <= 1'b0;
      shut_s2 <= 1'b0;
    end else begin
      sel_s1 <= config_sel_pin;
      sel_s2 <= sel_s1;
      shut_s1 <= shutdown_enable_pin;
      shut_s2 <= shut_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // field decode

  clk6_cfg_pkg::out_ctrl_t ctrl;
  clk6_cfg_pkg::spread_cfg_t ss_cfg;
  logic [1:0] mode_a, mode_b, active_mode;
  logic [9:0] q_a, q_b, active_q;
  logic [10:0] ratio;  // divide ratio in force
  logic out_enabled;   // output running rather than parked
  logic [47:0] delta_flat;

  always_comb begin
    ctrl.drive_mode = out_ctrl[clk6_cfg_pkg::CTRL_OEM_LSB +: 2];
    ctrl.invert = out_ctrl[clk6_cfg_pkg::CTRL_INV_BIT];
    mode_a = div_lo[clk6_cfg_pkg::DIV_MODE_A_LSB +: 2];
    mode_b = div_lo[clk6_cfg_pkg::DIV_MODE_B_LSB +: 2];
    q_a = {div_hi_a, div_lo[clk6_cfg_pkg::DIV_Q_A_LSB +: 2]};
    q_b = {div_hi_b, div_lo[clk6_cfg_pkg::DIV_Q_B_LSB +: 2]};
    // set b only when multi-configuration operation is on and selected
    if (multi_config_operation && sel_s2) begin
      active_mode = mode_b;
      active_q = q_b;
    end else begin
      active_mode = mode_a;
      active_q = q_a;
    end
    ratio = divide_ratio(active_mode, active_q);
    // a zero mode in either set keeps the output parked
    out_enabled = out_f_enable_bit && shut_s2
      && mode_a != clk6_cfg_pkg::DIV_MODE_OFF && mode_b != clk6_cfg_pkg::DIV_MODE_OFF;
    ss_cfg.step_period = ss_step[clk6_cfg_pkg::SS_PERIOD_LSB +: 4];
    ss_cfg.sample_count = ss_step[clk6_cfg_pkg::SS_COUNT_LSB +: 4];
    ss_cfg.dither = ss_dith[clk6_cfg_pkg::SS_DITHER_BIT];
    ss_cfg.start_offset = ss_dith[clk6_cfg_pkg::SS_OFFSET_LSB +: 6];
    for (int i = 0; i < clk6_cfg_pkg::SS_DELTA_REGS; i++) begin
      delta_flat[i*8 +: 8] = ss_delta[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output divider and pin drive

  logic [10:0] div_cnt, next_div_cnt; // source ticks within one output period
  logic div_phase, next_div_phase;    // divided clock before polarity
  logic next_out, next_oe;
  logic next_doubler;

  // the divider restarts while parked so the first period is whole
  always_comb begin
    next_div_cnt = div_cnt;
    next_div_phase = div_phase;
    next_out = 1'b0;
    next_oe = 1'b0;
    if (!out_enabled || ratio == 11'h000) begin
      next_div_cnt = 11'h000;
      next_div_phase = 1'b0;
    end else if (src_tick) begin
      if (ratio == 11'h001) begin
        next_div_phase = ~div_phase; // pass-through follows every source edge
      end else begin
        // a shrunken ratio can leave the count above the end; wrap at once
        if (div_cnt >= ratio - 11'h001) begin
          next_div_cnt = 11'h000;
        end else begin
          next_div_cnt = div_cnt + 11'h001;
        end
        next_div_phase = next_div_cnt < (ratio >> 1);
      end
    end
    if (out_enabled) begin
      next_out = div_phase ^ ctrl.invert;
      next_oe = 1'b1;
    end else begin
      case (ctrl.drive_mode)
        clk6_cfg_pkg::OEM_PARK_LOW: begin
          next_out = 1'b0;
          next_oe = 1'b1;
        end
        clk6_cfg_pkg::OEM_PARK_HIGH: begin
          next_out = 1'b1;
          next_oe = 1'b1;
        end
        default: begin
          next_out = 1'b0; // released, pin floats
          next_oe = 1'b0;
        end
      endcase
    end
    next_doubler = ss_dith[clk6_cfg_pkg::SS_DOUBLER_BIT];
  end

  // divider and pin flops
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt <= 11'h000;
      div_phase <= 1'b0;
      sixth_clock_output <= 1'b0;
      sixth_clock_output_oe <= 1'b0;
      pll_a_doubler <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      div_phase <= next_div_phase;
      sixth_clock_output <= next_out;
      sixth_clock_output_oe <= next_oe;
      pll_a_doubler <= next_doubler;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // spread sequencer

  spread_seq u_spread (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .cfg(ss_cfg),
    .deltas(delta_flat),
    .frac_word(pll_a_spread_frac),
    .step_pulse(pll_a_spread_step),
    .spread_active(pll_a_spread_active),
    .dither_lsb(pll_a_lsb_dither)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_park_high: assert property (@(posedge core_clk) disable iff (!rst_b)
    !out_enabled && ctrl.drive_mode == clk6_cfg_pkg::OEM_PARK_HIGH
      |=> sixth_clock_output && sixth_clock_output_oe)
    else $error("disabled output not parked high");

  a_float_default: assert property (@(posedge core_clk) disable iff (!rst_b)
    !out_enabled && !ctrl.drive_mode[1] |=> !sixth_clock_output_oe)
    else $error("disabled output not released");

  a_zero_set_parks: assert property (@(posedge core_clk) disable iff (!rst_b)
    (mode_a == clk6_cfg_pkg::DIV_MODE_OFF || mode_b == clk6_cfg_pkg::DIV_MODE_OFF)
      |=> sixth_clock_output == ($past(ctrl.drive_mode) == clk6_cfg_pkg::OEM_PARK_HIGH))
    else $error("output ran with a zero mode copy");

  a_div_two_toggle: assert property (@(posedge core_clk) disable iff (!rst_b)
    out_enabled && ratio == 11'h002 && src_tick
      |=> div_phase == (div_cnt == 11'h000))
    else $error("divide by two did not toggle");

  a_polarity_path: assert property (@(posedge core_clk) disable iff (!rst_b)
    out_enabled
      |=> sixth_clock_output == ($past(div_phase) ^ $past(ctrl.invert)) && sixth_clock_output_oe)
    else $error("polarity select not applied");

  a_set_b_ratio: assert property (@(posedge core_clk) disable iff (!rst_b)
    multi_config_operation && sel_s2 && mode_b == clk6_cfg_pkg::DIV_MODE_BYQ
      |-> ratio == {1'b0, q_b} + 11'h002)
    else $error("set b divider not in force");

endmodule

// [tb_top.sv]
// self-checking bench for the sixth output bank and first-pll spread configuration
`timescale 1ns/1ns
module tb_top;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] cfg_addr = 8'h00;
  logic [7:0] cfg_wdata = 8'h00;
  logic cfg_wr = 1'b0;
  logic cfg_rd = 1'b0;
  logic [7:0] cfg_rdata;
  logic src_tick = 1'b0;
  logic tick_on = 1'b0; // source pulses every cycle while set
  logic multi_config_operation = 1'b0;
  logic config_sel_pin = 1'b0;
  logic out_f_enable_bit = 1'b0;
  logic shutdown_enable_pin = 1'b0;
  logic sixth_clock_output, sixth_clock_output_oe;
  logic [7:0] pll_a_spread_frac;
  logic pll_a_spread_step, pll_a_spread_active, pll_a_lsb_dither, pll_a_doubler;
  int bad_count = 0;
  int samples_checked = 0;
  output6_divider_and_spread_cfg u_output6_divider_and_spread_cfg (.core_clk(core_clk),
    .rst_b(rst_b), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata), .src_tick(src_tick),
    .multi_config_operation(multi_config_operation), .config_sel_pin(config_sel_pin),
    .out_f_enable_bit(out_f_enable_bit), .shutdown_enable_pin(shutdown_enable_pin),
    .sixth_clock_output(sixth_clock_output), .sixth_clock_output_oe(sixth_clock_output_oe),
    .pll_a_spread_frac(pll_a_spread_frac), .pll_a_spread_step(pll_a_spread_step),
    .pll_a_spread_active(pll_a_spread_active), .pll_a_lsb_dither(pll_a_lsb_dither),
    .pll_a_doubler(pll_a_doubler));
  //////////////////////////////////////////////////////////////////////////////
  // 100 ns clock; source pulses launched on the falling edge
  initial begin
    forever #50 core_clk = ~core_clk;
  end
  always @(negedge core_clk) begin
    src_tick <= tick_on;
  end
  // verdict in one place
  task automatic stop_test();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // one comparison; an unknown condition counts as a miss
  task automatic check(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // register write: strobe held for exactly one rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    cfg_addr = a;
    cfg_wdata = d;
    cfg_wr = 1'b1;
    @(negedge core_clk);
    cfg_wr = 1'b0;
  endtask
  // register read: data stands for the cycle after the strobe edge
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(negedge core_clk);
    cfg_addr = a;
    cfg_rd = 1'b1;
    @(negedge core_clk);
    cfg_rd = 1'b0;
    check(cfg_rdata === e, "register read");
  endtask
  // counts output rises over n cycles, compared with a tolerance of one for phase
  task automatic rises_chk(input int n, input int e);
    int r;
    logic prev;
    r = 0;
    prev = sixth_clock_output;
    repeat (n) begin
      @(negedge core_clk);
      if (sixth_clock_output === 1'b1 && prev === 1'b0) r++;
      prev = sixth_clock_output;
    end
    check(r >= e - 1 && r <= e + 1, "output rise count");
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // reset values, reserved control bits and an unmapped address
  task automatic t_regs();
    rd_chk(clk6_cfg_pkg::SIXTH_CLOCK_OUTPUT_CTRL_ADDR, 8'h00);
    rd_chk(clk6_cfg_pkg::SIXTH_CLOCK_OUTPUT_DIV_LO_ADDR, 8'hBB);
    rd_chk(clk6_cfg_pkg::SIXTH_CLOCK_OUTPUT_DIV_HI_A_ADDR, 8'h00);
    rd_chk(clk6_cfg_pkg::SS_STEP_ADDR, 8'h00);
    rd_chk(clk6_cfg_pkg::SS_DITH_ADDR, 8'h00);
    rd_chk(8'hF0, 8'h00);
    wr(clk6_cfg_pkg::SIXTH_CLOCK_OUTPUT_CTRL_ADDR, 8'hFF);
    rd_chk(clk6_cfg_pkg::SIXTH_CLOCK_OUTPUT_CTRL_ADDR, 8'hF4);
    wr(clk6_cfg_pkg::SIXTH_CLOCK_OUTPUT_CTRL_ADDR, 8'h00);
  endtask
  // every divide mode, both divider copies, and one copy of mode cleared
  task automatic t_divide();
    out_f_enable_bit = 1'b1;
    shutdown_enable_pin = 1'b1;
    tick_on = 1'b1;
    wr(clk6_cfg_pkg::SIXTH_CLOCK_OUTPUT_DIV_LO_ADDR, 8'hBB);
    cycles(4);
    check(sixth_clock_output_oe === 1'b1, "output not driven");
    rises_chk(56, 14);
    wr(clk6_cfg_pkg::SIXTH_CLOCK_OUTPUT_DIV_LO_ADDR, 8'hAA);
    rises_chk(56, 28);
    wr(clk6_cfg_pkg::SIXTH_CLOCK_OUTPUT_DIV_LO_ADDR, 8'h99);
    rises_chk(56, 28);
    wr(clk6_cfg_pkg::SIXTH_CLOCK_OUTPUT_DIV_HI_A_ADDR, 8'h01);
    wr(clk6_cfg_pkg::SIXTH_CLOCK_OUTPUT_DIV_LO_ADDR, 8'hB7);
    rises_chk(56, 8);
    multi_config_operation = 1'b1;
    config_sel_pin = 1'b1;
    cycles(4);
    rises_chk(56, 14);
    wr(clk6_cfg_pkg::SIXTH_CLOCK_OUTPUT_DIV_LO_ADDR, 8'hB4);
    cycles(3);
    check(sixth_clock_output_oe === 1'b0, "enabled with a zero mode copy");
    rises_chk(20, 0);
    wr(clk6_cfg_pkg::SIXTH_CLOCK_OUTPUT_DIV_LO_ADDR, 8'hBB);
  endtask
  // polarity flip with the divider frozen, then the disabled drive modes
  task automatic t_drive();
    logic lvl;
    tick_on = 1'b0;
    cycles(4);
    lvl = sixth_clock_output;
    wr(clk6_cfg_pkg::SIXTH_CLOCK_OUTPUT_CTRL_ADDR, 8'h04);
    cycles(3);
    check(sixth_clock_output === ~lvl, "polarity not inverted");
    out_f_enable_bit = 1'b0;
    wr(clk6_cfg_pkg::SIXTH_CLOCK_OUTPUT_CTRL_ADDR, 8'h80);
    cycles(3);
    check(sixth_clock_output_oe === 1'b1 && sixth_clock_output === 1'b0, "park low");
    wr(clk6_cfg_pkg::SIXTH_CLOCK_OUTPUT_CTRL_ADDR, 8'h40);
    cycles(3);
    check(sixth_clock_output_oe === 1'b0, "float");
    out_f_enable_bit = 1'b1;
    shutdown_enable_pin = 1'b0;
    wr(clk6_cfg_pkg::SIXTH_CLOCK_OUTPUT_CTRL_ADDR, 8'hC0);
    cycles(4);
    check(sixth_clock_output_oe === 1'b1 && sixth_clock_output === 1'b1, "park high");
  endtask
  // spread walk: offset 4, deltas 1 and 2, three samples, step every two cycles
  task automatic t_spread();
    logic [7:0] seen[$];
    logic [7:0] prev;
    int pulses;
    pulses = 0;
    wr(clk6_cfg_pkg::SS_DELTA_BASE_ADDR, 8'h21);
    wr(clk6_cfg_pkg::SS_DITH_ADDR, 8'h04);
    cycles(2);
    check(pll_a_spread_frac === 8'h04 && pll_a_spread_active === 1'b0, "idle offset");
    wr(clk6_cfg_pkg::SS_STEP_ADDR, 8'h23);
    prev = pll_a_spread_frac;
    repeat (24) begin
      @(negedge core_clk);
      if (pll_a_spread_step === 1'b1) pulses++;
      if (pll_a_spread_frac !== prev) seen.push_back(pll_a_spread_frac);
      prev = pll_a_spread_frac;
    end
    check(pulses >= 11 && pulses <= 12 && pll_a_spread_active === 1'b1, "step spacing");
    check(seen.size() >= 5, "too few waveform points");
    if (seen.size() >= 5) begin
      check(seen[0] === 8'h05 && seen[1] === 8'h07, "delta accumulation");
      check(seen[2] === 8'h04 && seen[3] === 8'h05 && seen[4] === 8'h07, "wrap");
    end
    wr(clk6_cfg_pkg::SS_STEP_ADDR, 8'h03);
    cycles(3);
    pulses = 0;
    repeat (10) begin
      @(negedge core_clk);
      if (pll_a_spread_step !== 1'b0) pulses++;
    end
    check(pulses == 0 && pll_a_spread_active === 1'b0, "spread not stopped");
    check(pll_a_spread_frac === 8'h04, "offset after stop");
  endtask
  // dither bit gates the lsb toggling
  task automatic t_dither();
    int ones;
    ones = 0;
    wr(clk6_cfg_pkg::SS_DITH_ADDR, 8'hC4);
    repeat (40) begin
      @(negedge core_clk);
      if (pll_a_lsb_dither === 1'b1) ones++;
    end
    check(ones > 0 && ones < 40 && pll_a_doubler === 1'b1, "dither not toggling");
    wr(clk6_cfg_pkg::SS_DITH_ADDR, 8'h04);
    cycles(2);
    ones = 0;
    repeat (20) begin
      @(negedge core_clk);
      if (pll_a_lsb_dither !== 1'b0) ones++;
    end
    check(ones == 0 && pll_a_doubler === 1'b0, "dither while off");
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // main sequence: reset held eight cycles, released on a falling edge
  initial begin
    cycles(8);
    rst_b = 1'b1;
    cycles(2);
    t_regs();
    t_divide();
    t_drive();
    t_spread();
    t_dither();
    stop_test();
  end
  // watchdog: the sequence needs well under two thousand cycles
  initial begin
    #(20000 * 100);
    bad_count++;
    stop_test();
  end
endmodule
